// ===== hdl/cspc_consts.svh
// Overview of operation
// - Bit 25 is set by any card access, cleared by a read of the register unless an access comes in the same cycle, and zero after reset.
// - Read-only bit 24 reads 0 while the card clock runs normally and 1 once it changed.
// - Read/write bit 16 enables clock control; while it is zero bit 0 has no effect.
// - With control enabled and bit 0 zero, the clock-run logic may stop the card clock.
// - With control enabled and bit 0 one, the clock-run logic may slow the card clock by 16.
// - The card clock is stopped or slowed only while the card interface is idle.
// - Bits 31-26, 23-17 and 15-1 are read-only, always read zero and ignore writes.
// - The register sits at offset 20h of the socket base and reads all zero after reset.
// - With the policy bit clear, gating also needs the host clock stopping or slowing.
`ifndef CSPC_CONSTS_SVH
`define CSPC_CONSTS_SVH

`define CSPC_OFF_POLICY   8'h10
`define CSPC_OFF_PM       8'h20
`define CSPC_OFF_IRQ_STAT 8'h24
`define CSPC_OFF_IRQ_MASK 8'h28

`define CSPC_BIT_POLICY   7
`define CSPC_BIT_ACCESS   25
`define CSPC_BIT_CHANGED  24
`define CSPC_BIT_ENABLE   16
`define CSPC_BIT_SELECT   0
`define CSPC_PM_RESET     32'h0000_0000
`define CSPC_PM_RSVD_MASK 32'hFCFE_FFFE

`define CSPC_EV_ACCESS    0
`define CSPC_EV_CHANGED   1
`define CSPC_EV_RESTORED  2
`define CSPC_EV_NUM       3

`define CSPC_SLOW_DIV     16
`define CSPC_CLK_NS       40
`define CSPC_OBJ_WIN_NS   200
`define CSPC_OBJ_CYCLES   ((`CSPC_OBJ_WIN_NS + `CSPC_CLK_NS - 1) / `CSPC_CLK_NS)

`endif

// ===== hdl/cspc_pkg.sv
package cspc_pkg;

	typedef enum logic [1:0] {
		CSPC_RUN,
		CSPC_RELEASE,
		CSPC_GATED,
		CSPC_RESTART
	} cspc_state_t;

	typedef logic [31:0] cspc_word_t;

endpackage

// ===== hdl/cspc_top.sv
`timescale 1ns/10ps
`include "cspc_consts.svh"

module cspc_top
	import cspc_pkg::*;
#(
	parameter int OBJ_CYCLES = `CSPC_OBJ_CYCLES,
	parameter int SLOW_DIV   = `CSPC_SLOW_DIV
) (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        card_busy,
	input  wire logic        card_access,
	input  wire logic        host_clk_slowing,
	input  wire logic        cclkrun_n_i,
	output logic             cclkrun_n_o,
	output logic             cclkrun_n_oe,
	output logic             card_clk_stop,
	output logic             card_clk_slow,
	output logic             card_clk_tick,
	output logic             irq
);

	localparam int OBJ_W = $clog2(OBJ_CYCLES + 1);
	localparam int DIV_W = $clog2(SLOW_DIV);
	localparam logic [OBJ_W-1:0] OBJ_LAST = OBJ_W'(OBJ_CYCLES - 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SLOW_DIV - 1);

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		hit = (addr == off);
	endfunction

	logic                     policy_q;
	logic                     enable_q;
	logic                     select_q;
	logic                     access_q;
	logic                     changed_q;
	logic                     gate_slow_q;
	logic [`CSPC_EV_NUM-1:0]  stat_q;
	logic [`CSPC_EV_NUM-1:0]  mask_q;
	logic [`CSPC_EV_NUM-1:0]  ev_set;
	logic [OBJ_W-1:0]         obj_cnt_q;
	logic [DIV_W-1:0]         div_q;
	cspc_state_t              state_q;
	cspc_state_t              state_d;
	logic                     idle_ok;
	logic                     wr_pm;
	logic                     rd_pm;
	cspc_word_t               pm_word;
	cspc_word_t               rdata_d;

	assign wr_pm = reg_wr && hit(reg_addr, `CSPC_OFF_PM);
	assign rd_pm = reg_rd && hit(reg_addr, `CSPC_OFF_PM);

	// Only the documented fields are assembled; all other bit positions stay zero.
	always_comb begin
		pm_word = `CSPC_PM_RESET;
		pm_word[`CSPC_BIT_ACCESS]  = access_q;
		pm_word[`CSPC_BIT_CHANGED] = changed_q;
		pm_word[`CSPC_BIT_ENABLE]  = enable_q;
		pm_word[`CSPC_BIT_SELECT]  = select_q;
	end

	// Control bits; writes to reserved positions are dropped by construction.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_q <= 1'b0;
			select_q <= 1'b0;
		end else if (wr_pm) begin
			enable_q <= reg_wdata[`CSPC_BIT_ENABLE];
			select_q <= reg_wdata[`CSPC_BIT_SELECT];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			policy_q <= 1'b0;
		end else if (reg_wr && hit(reg_addr, `CSPC_OFF_POLICY)) begin
			policy_q <= reg_wdata[`CSPC_BIT_POLICY];
		end
	end

	// A new access in the same cycle as the clearing read wins, so it is not lost.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			access_q <= 1'b0;
		end else if (card_access) begin
			access_q <= 1'b1;
		end else if (rd_pm) begin
			access_q <= 1'b0;
		end
	end

	// Gating is considered only when enabled, idle and allowed by the policy.
	assign idle_ok = enable_q && !card_busy && !card_access
		&& (policy_q || host_clk_slowing);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			CSPC_RUN: begin
				if (idle_ok) begin
					state_d = CSPC_RELEASE;
				end
			end
			CSPC_RELEASE: begin
				// The card objects by holding the line low; activity also aborts the attempt.
				if (!cclkrun_n_i || !idle_ok) begin
					state_d = CSPC_RUN;
				end else if (obj_cnt_q == OBJ_LAST) begin
					state_d = CSPC_GATED;
				end
			end
			CSPC_GATED: begin
				if (!cclkrun_n_i || !enable_q || card_busy || card_access) begin
					state_d = CSPC_RESTART;
				end
			end
			CSPC_RESTART: begin
				state_d = CSPC_RUN;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= CSPC_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			obj_cnt_q <= '0;
		end else if (state_q == CSPC_RELEASE) begin
			obj_cnt_q <= obj_cnt_q + 1'b1;
		end else begin
			obj_cnt_q <= '0;
		end
	end

	// The mode is frozen on entry so a later write cannot change a gated clock mid-way.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gate_slow_q <= 1'b0;
		end else if (state_q == CSPC_RELEASE && state_d == CSPC_GATED) begin
			gate_slow_q <= select_q;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			changed_q <= 1'b0;
		end else begin
			changed_q <= (state_d == CSPC_GATED);
		end
	end

	// The line is driven low in the run and restart states, and released in the release and gated states.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cclkrun_n_o  <= 1'b0;
			cclkrun_n_oe <= 1'b1;
		end else begin
			cclkrun_n_o  <= 1'b0;
			cclkrun_n_oe <= (state_d == CSPC_RUN) || (state_d == CSPC_RESTART);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			card_clk_stop <= 1'b0;
			card_clk_slow <= 1'b0;
		end else begin
			card_clk_stop <= (state_d == CSPC_GATED) && !gate_slow_q_next();
			card_clk_slow <= (state_d == CSPC_GATED) && gate_slow_q_next();
		end
	end

	function automatic logic gate_slow_q_next();
		if (state_q == CSPC_RELEASE) begin
			gate_slow_q_next = select_q;
		end else begin
			gate_slow_q_next = gate_slow_q;
		end
	endfunction

	// The tick is the clock enable for the card clock generator.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q         <= '0;
			card_clk_tick <= 1'b1;
		end else if (state_d != CSPC_GATED) begin
			div_q         <= '0;
			card_clk_tick <= 1'b1;
		end else if (!gate_slow_q_next()) begin
			div_q         <= '0;
			card_clk_tick <= 1'b0;
		end else begin
			div_q         <= (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
			card_clk_tick <= (div_q == DIV_LAST);
		end
	end

	assign ev_set[`CSPC_EV_ACCESS]   = card_access;
	assign ev_set[`CSPC_EV_CHANGED]  = (state_q == CSPC_RELEASE) && (state_d == CSPC_GATED);
	assign ev_set[`CSPC_EV_RESTORED] = (state_q == CSPC_RESTART);

	// Set wins over a clearing write of one in the same cycle.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_q <= '0;
		end else if (reg_wr && hit(reg_addr, `CSPC_OFF_IRQ_STAT)) begin
			stat_q <= (stat_q & ~reg_wdata[`CSPC_EV_NUM-1:0]) | ev_set;
		end else begin
			stat_q <= stat_q | ev_set;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_q <= '0;
		end else if (reg_wr && hit(reg_addr, `CSPC_OFF_IRQ_MASK)) begin
			mask_q <= reg_wdata[`CSPC_EV_NUM-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |((stat_q | ev_set) & mask_q);
		end
	end

	always_comb begin
		rdata_d = '0;
		if (hit(reg_addr, `CSPC_OFF_PM)) begin
			rdata_d = pm_word;
		end else if (hit(reg_addr, `CSPC_OFF_POLICY)) begin
			rdata_d[`CSPC_BIT_POLICY] = policy_q;
		end else if (hit(reg_addr, `CSPC_OFF_IRQ_STAT)) begin
			rdata_d[`CSPC_EV_NUM-1:0] = stat_q;
		end else if (hit(reg_addr, `CSPC_OFF_IRQ_MASK)) begin
			rdata_d[`CSPC_EV_NUM-1:0] = mask_q;
		end
	end

	// Read data stand for the one cycle after the strobe and are zero otherwise.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= rdata_d;
		end else begin
			reg_rdata <= '0;
		end
	end

	logic [4:0] slow_run_q;
	logic [4:0] gap_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			slow_run_q <= '0;
			gap_q      <= '0;
		end else begin
			slow_run_q <= !card_clk_slow ? '0 : (slow_run_q == 5'h1F) ? slow_run_q : slow_run_q + 1'b1;
			gap_q      <= card_clk_tick ? '0 : (gap_q == 5'h1F) ? gap_q : gap_q + 1'b1;
		end
	end

	a_access_set: assert property (@(posedge core_clk) disable iff (!rst_n)
		card_access |=> access_q)
		else $error("card access did not set the access flag");

	a_access_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
		rd_pm && !card_access |=> !access_q ##1 ($past(reg_rd) || reg_rdata == '0))
		else $error("read did not clear the access flag");

	a_mode_read: assert property (@(posedge core_clk) disable iff (!rst_n)
		rd_pm |=> reg_rdata[`CSPC_BIT_CHANGED] == $past(state_q == CSPC_GATED))
		else $error("clock mode bit does not follow gating");

	a_enable_gates: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_q == CSPC_RUN && !enable_q) |=> state_q == CSPC_RUN)
		else $error("clock gating started while control disabled");

	a_stop_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_q == CSPC_GATED && !gate_slow_q) |-> card_clk_stop && !card_clk_tick)
		else $error("stop mode did not stop the card clock");

	a_slow_div: assert property (@(posedge core_clk) disable iff (!rst_n)
		(card_clk_tick && card_clk_slow && slow_run_q > 5'h10) |-> gap_q == 5'h0F)
		else $error("slowed clock is not divided by sixteen");

	a_busy_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_q == CSPC_RUN && card_busy) |=> state_q == CSPC_RUN)
		else $error("gating attempted during a transfer");

	a_rsvd_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
		rd_pm |=> (reg_rdata & `CSPC_PM_RSVD_MASK) == '0)
		else $error("reserved bits read nonzero");

	a_pm_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr_pm |=> enable_q == $past(reg_wdata[`CSPC_BIT_ENABLE])
			&& select_q == $past(reg_wdata[`CSPC_BIT_SELECT]))
		else $error("register write did not take effect");

	a_policy_host: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_q == CSPC_RUN && !policy_q && !host_clk_slowing) |=> state_q == CSPC_RUN)
		else $error("gating without policy or host clock slowing");

	a_card_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_q == CSPC_GATED && !cclkrun_n_i) |=> cclkrun_n_oe && !card_clk_stop
			&& !card_clk_slow ##1 state_q == CSPC_RUN)
		else $error("card restart request not honoured");

	a_object_abort: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_q == CSPC_RELEASE && !cclkrun_n_i) |=> state_q == CSPC_RUN && cclkrun_n_oe)
		else $error("card objection ignored");

endmodule

// ===== sim/cspc_card_model.sv
`timescale 1ns/10ps

module cspc_card_model (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       line,
	input  wire logic       want_fast,
	input  wire logic [3:0] lat,
	output logic            card_pull
);
	logic [3:0] wait_q;

	// A late reply misses the objection window, so a slow card asks for a restart, then keeps the line low and objects to later releases.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_q    <= 4'h0;
			card_pull <= 1'b0;
		end else if (!want_fast) begin
			wait_q    <= 4'h0;
			card_pull <= 1'b0;
		end else if (wait_q < lat) begin
			wait_q <= wait_q + 4'h1;
		end else if (line) begin
			card_pull <= 1'b1;
		end
	end
endmodule

// ===== sim/test_cspc_top.sv
`timescale 1ns/10ps

module test_cspc_top;
	import cspc_pkg::*;
	logic       core_clk, rst_n, reg_wr, reg_rd, card_busy, card_access;
	logic       host_clk_slowing, want_fast, card_pull, cclkrun_n_o, cclkrun_n_oe;
	logic       card_clk_stop, card_clk_slow, card_clk_tick, irq;
	logic [3:0] lat;
	logic [7:0] reg_addr;
	cspc_word_t reg_wdata, reg_rdata;
	int         errors, samples_checked, n;
	// Open-drain line with a pull-up: low while either side pulls it.
	wire        line = !((cclkrun_n_oe && !cclkrun_n_o) || card_pull);

	cspc_top #(.OBJ_CYCLES(2), .SLOW_DIV(16)) u_cspc_top (.core_clk(core_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .card_busy(card_busy), .card_access(card_access),
		.host_clk_slowing(host_clk_slowing), .cclkrun_n_i(line), .cclkrun_n_o(cclkrun_n_o),
		.cclkrun_n_oe(cclkrun_n_oe), .card_clk_stop(card_clk_stop),
		.card_clk_slow(card_clk_slow), .card_clk_tick(card_clk_tick), .irq(irq));
	cspc_card_model u_cspc_card_model (.core_clk(core_clk), .rst_n(rst_n), .line(line),
		.want_fast(want_fast), .lat(lat), .card_pull(card_pull));

	task automatic results();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input cspc_word_t got, input cspc_word_t exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input cspc_word_t d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input cspc_word_t exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask

	task automatic wgate(input logic v);
		for (int i = 0; i < 30; i++) begin
			@(posedge core_clk);
			#1;
			if ((card_clk_stop | card_clk_slow) === v)
				return;
		end
		errors++;
		$display("ERROR %0t clock gating wait ran out", $time);
		results();
	endtask

	task automatic stay(input int cyc);
		logic bad;
		bad = 1'b0;
		repeat (cyc) begin
			@(posedge core_clk);
			#1;
			bad = bad | (card_clk_stop !== 1'b0) | (card_clk_slow !== 1'b0);
		end
		chk(32'(bad), 32'h0000_0000);
	endtask

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	initial begin
		{rst_n, reg_wr, reg_rd, card_busy, card_access, host_clk_slowing, want_fast} = 7'h00;
		{lat, reg_addr, reg_wdata} = 44'h0;
		errors = 0;
		samples_checked = 0;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(8'h20, 32'h0000_0000);
		chk(32'({cclkrun_n_oe, cclkrun_n_o}), 32'h0000_0002);
		rd(8'h04, 32'h0000_0000);
		wr(8'h20, 32'hFFFF_FFFF);
		rd(8'h20, 32'h0001_0001);
		stay(20);
		host_clk_slowing <= 1'b1;
		wgate(1'b1);
		chk(32'(card_clk_slow), 32'h0000_0001);
		chk(32'({cclkrun_n_oe, cclkrun_n_o}), 32'h0000_0000);
		n = 0;
		repeat (32) begin
			@(posedge core_clk);
			#1;
			n += int'(card_clk_tick);
		end
		chk(32'(n), 32'h0000_0002);
		rd(8'h20, 32'h0101_0001);
		chk(32'(irq), 32'h0000_0000);
		rd(8'h24, 32'h0000_0002);
		wr(8'h28, 32'h0000_0006);
		repeat (2) @(posedge core_clk);
		#1;
		chk(32'(irq), 32'h0000_0001);
		wr(8'h24, 32'h0000_0002);
		repeat (2) @(posedge core_clk);
		#1;
		chk(32'(irq), 32'h0000_0000);
		lat       <= 4'h3;
		want_fast <= 1'b1;
		wgate(1'b0);
		chk(32'(card_clk_tick), 32'h0000_0001);
		stay(20);
		rd(8'h24, 32'h0000_0004);
		chk(32'(irq), 32'h0000_0001);
		wr(8'h24, 32'h0000_0004);
		want_fast <= 1'b0;
		card_busy <= 1'b1;
		wr(8'h20, 32'h0001_0000);
		stay(20);
		card_busy <= 1'b0;
		wgate(1'b1);
		chk(32'(card_clk_stop), 32'h0000_0001);
		chk(32'(card_clk_tick), 32'h0000_0000);
		card_access <= 1'b1;
		card_busy   <= 1'b1;
		@(posedge core_clk);
		card_access <= 1'b0;
		wgate(1'b0);
		rd(8'h20, 32'h0201_0000);
		rd(8'h20, 32'h0001_0000);
		card_busy <= 1'b0;
		wgate(1'b1);
		wr(8'h20, 32'h0000_0000);
		wgate(1'b0);
		stay(20);
		host_clk_slowing <= 1'b0;
		wr(8'h10, 32'hFFFF_FFFF);
		rd(8'h10, 32'h0000_0080);
		wr(8'h20, 32'h0001_0001);
		wgate(1'b1);
		chk(32'(card_clk_slow), 32'h0000_0001);
		results();
	end
endmodule
